/* File: test/dlir_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module dlir_bench
  import dlir_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [31:0] rd;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic irq;
  dlir_evt_t evt = '0;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;

  // one slave, so its hreadyout is the bus hready
  dlir_top u_dlir_top (.ref_clk_i(clk), .reset_i(rst), .ce_i(ce), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .evt_i(evt), .irq_o(irq));

  initial forever #5 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // waits on hready at both phases, so the master copes with wait states
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask : wr

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, '0, rd);
    chk(rd, exp);
  endtask : rdc

  task automatic pulse(input logic [3:0] v);
    @(posedge clk);
    evt <= dlir_evt_t'(v);
    @(posedge clk);
    evt <= '0;
    @(negedge clk);
  endtask : pulse

  task automatic irqc(input logic e);
    // look between edges, after the edge that moved the flags has settled
    @(negedge clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask : irqc

  task automatic t_reset();
    rdc(DLIR_OFS_ENABLE, 8'h00);
    rdc(DLIR_OFS_STATUS, 8'h00);
    rdc(DLIR_OFS_MASK, 8'h78);
    irqc(1'b0);
    chk({31'h0, hresp}, 32'h0000_0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_rw();
    wr(DLIR_OFS_ENABLE, 32'hFFFF_FFFF);
    rdc(DLIR_OFS_ENABLE, 8'h78);
    wr(DLIR_OFS_ENABLE, 32'h0000_0000);
    rdc(DLIR_OFS_ENABLE, 8'h00);
    rdc(32'h0000_0010, 8'h00);
    $display("test rw done");
  endtask : t_rw

  // with every enable off no event reaches the pin, yet each is still recorded
  task automatic t_quiet();
    wr(DLIR_OFS_ENABLE, 32'h0000_0000);
    for (int k = 0; k < 4; k++) begin
      pulse(4'h1 << k);
      irqc(1'b0);
      rdc(DLIR_OFS_STATUS, 8'h08 << k);
    end
    $display("test quiet done");
  endtask : t_quiet

  // an event on the edge that takes the status read must survive the clear
  task automatic t_race();
    wr(DLIR_OFS_ENABLE, 32'h0000_0020);
    fork
      bus(1'b0, DLIR_OFS_STATUS, '0, rd);
      pulse(4'h4);
    join
    chk(rd, 32'h0000_0000);
    irqc(1'b1);
    rdc(DLIR_OFS_STATUS, 8'h20);
    $display("test race done");
  endtask : t_race

  // enable one bit at a time; the others must not reach the interrupt
  task automatic t_events();
    for (int b = 3; b <= 6; b++) begin
      wr(DLIR_OFS_ENABLE, 8'h01 << b);
      pulse(4'hF & ~(4'h1 << (b - 3)));
      irqc(1'b0);
      rdc(DLIR_OFS_STATUS, 8'h78 & ~(8'h01 << b));
      rdc(DLIR_OFS_STATUS, 8'h00);
      pulse(4'h1 << (b - 3));
      irqc(1'b1);
      rdc(DLIR_OFS_STATUS, 8'h01 << b);
      irqc(1'b0);
    end
    $display("test events done");
  endtask : t_events

  task automatic t_mask();
    wr(DLIR_OFS_ENABLE, 8'h78);
    wr(DLIR_OFS_MASK, 8'h00);
    pulse(4'hF);
    irqc(1'b0);
    wr(DLIR_OFS_MASK, 8'h78);
    irqc(1'b1);
    wr(DLIR_OFS_STATUS, 8'h78);
    irqc(1'b0);
    rdc(DLIR_OFS_STATUS, 8'h00);
    // clock enable low freezes the block, so events are lost
    ce <= 1'b0;
    pulse(4'hF);
    chk({31'h0, hready}, 32'h0000_0000);
    irqc(1'b0);
    @(posedge clk);
    ce <= 1'b1;
    rdc(DLIR_OFS_STATUS, 8'h00);
    $display("test mask done");
  endtask : t_mask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_rw();
    t_quiet();
    t_events();
    t_race();
    t_mask();
    test_done();
  end
endmodule : dlir_bench
`default_nettype wire

/* File: verilog/dlir_evt_latch.sv */
`timescale 1ns/1ps
`default_nettype none
module dlir_evt_latch (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_o
);

  logic flag_q;
  logic flag_d;

  // set wins so an event landing on the clearing read is kept for the next one
  always_comb begin
    flag_d = set_i | (flag_q & ~clr_i); // R6
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      flag_q <= 1'b0;
    end else if (ce_i) begin
      flag_q <= flag_d;
    end
  end

  assign flag_o = flag_q;

endmodule : dlir_evt_latch
`default_nettype wire

/* File: verilog/dlir_pkg.sv */
// Contract
// R1: bit 6 enables the interrupt on transmit message start; resets to 0.
// R2: bit 5 enables the interrupt on receive message start; resets to 0.
// R3: bit 4 enables the interrupt on transmit message completion.
// R4: bit 3 enables the interrupt on complete message reception; resets to 0.
// R5: bit 7 reads zero and ignores writes; bit 4 also resets to 0.
// R6: event status bits clear when software reads the status register.
`default_nettype none
package dlir_pkg;

  localparam int unsigned DLIR_REG_W = 8;
  localparam int unsigned DLIR_DEC_W = 12;

  // register byte offsets inside the slave's window
  localparam logic [11:0] DLIR_OFS_ENABLE = 12'h000;
  localparam logic [11:0] DLIR_OFS_STATUS = 12'h004;
  localparam logic [11:0] DLIR_OFS_MASK = 12'h008;

  // field positions, shared by enable, status and mask
  localparam int unsigned DLIR_BIT_RESERVED = 7;
  localparam int unsigned DLIR_BIT_TX_BEGIN = 6;
  localparam int unsigned DLIR_BIT_RX_BEGIN = 5;
  localparam int unsigned DLIR_BIT_TX_DONE = 4;
  localparam int unsigned DLIR_BIT_RX_DONE = 3;

  localparam logic [7:0] DLIR_IMPL_BITS = 8'h78;
  localparam logic [7:0] DLIR_ENABLE_RST = 8'h00;
  localparam logic [7:0] DLIR_STATUS_RST = 8'h00;
  localparam logic [7:0] DLIR_MASK_RST = 8'h78;
  localparam logic [23:0] DLIR_RDATA_PAD = 24'h00_0000;

  localparam int unsigned DLIR_HTRANS_ACTIVE_BIT = 1;
  localparam logic DLIR_HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    DLIR_SEL_NONE = 2'b00,
    DLIR_SEL_ENABLE = 2'b01,
    DLIR_SEL_STATUS = 2'b11,
    DLIR_SEL_MASK = 2'b10
  } dlir_sel_t;

  // order matches bits 6..3
  typedef struct packed {
    logic tx_begin;
    logic rx_begin;
    logic tx_done;
    logic rx_done;
  } dlir_evt_t;

  typedef struct packed {
    logic write;
    dlir_sel_t sel;
  } dlir_dphase_t;

  function automatic dlir_sel_t dlir_decode(input logic [11:0] addr);
    case (addr)
      DLIR_OFS_ENABLE: dlir_decode = DLIR_SEL_ENABLE;
      DLIR_OFS_STATUS: dlir_decode = DLIR_SEL_STATUS;
      DLIR_OFS_MASK: dlir_decode = DLIR_SEL_MASK;
      default: dlir_decode = DLIR_SEL_NONE;
    endcase
  endfunction : dlir_decode

endpackage : dlir_pkg
`default_nettype wire

/* File: verilog/dlir_top.sv */
// Chosen here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module dlir_top
  import dlir_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire dlir_evt_t evt_i,
  output logic irq_o
);

  logic accept;
  dlir_sel_t ap_sel;
  logic rd_status;
  logic wr_enable;
  logic wr_status;
  logic wr_mask;
  logic [7:0] wbyte;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic [7:0] status_q;
  logic [7:0] pending;

  dlir_dphase_t dp_q;
  dlir_dphase_t dp_d;
  logic [7:0] enable_q;
  logic [7:0] enable_d;
  logic [7:0] mask_q;
  logic [7:0] mask_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // address phase; size is not checked, only whole-word singles are expected
  assign accept = hsel_i & hready_i & htrans_i[DLIR_HTRANS_ACTIVE_BIT] & ce_i;
  assign ap_sel = dlir_decode(haddr_i[DLIR_DEC_W-1:0]);
  assign rd_status = accept & ~hwrite_i & (ap_sel == DLIR_SEL_STATUS);

  // data phase
  assign wr_enable = dp_q.write & (dp_q.sel == DLIR_SEL_ENABLE);
  assign wr_status = dp_q.write & (dp_q.sel == DLIR_SEL_STATUS);
  assign wr_mask = dp_q.write & (dp_q.sel == DLIR_SEL_MASK);
  assign wbyte = hwdata_i[DLIR_REG_W-1:0] & DLIR_IMPL_BITS; // R5

  always_comb begin
    dp_d = '0;
    if (accept) begin
      dp_d.write = hwrite_i;
      dp_d.sel = ap_sel;
    end
    enable_d = enable_q;
    if (wr_enable) begin
      enable_d = wbyte; // R1 R2 R3 R4
    end
    mask_d = mask_q;
    if (wr_mask) begin
      mask_d = wbyte;
    end
    // enable and mask read data use next values so a read right after a write sees it; status reads use status_q
    rdata_d = rdata_q;
    if (accept && !hwrite_i) begin
      case (ap_sel)
        DLIR_SEL_ENABLE: rdata_d = {DLIR_RDATA_PAD, enable_d}; // R5
        DLIR_SEL_STATUS: rdata_d = {DLIR_RDATA_PAD, status_q};
        DLIR_SEL_MASK: rdata_d = {DLIR_RDATA_PAD, mask_d};
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      dp_q <= '0;
      enable_q <= DLIR_ENABLE_RST; // R1 R2 R4 R5
      mask_q <= DLIR_MASK_RST;
      rdata_q <= '0;
    end else if (ce_i) begin
      dp_q <= dp_d;
      enable_q <= enable_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
    end
  end

  // status: reading clears all, writing ones clears chosen bits
  // a read racing an event returns the old flags; the event stays for the next read
  assign set_vec = {1'b0, evt_i, 3'b000};
  assign clr_vec = (rd_status ? DLIR_IMPL_BITS : DLIR_STATUS_RST) | (wr_status ? wbyte : DLIR_STATUS_RST); // R6

  generate
    for (genvar i = 0; i < DLIR_REG_W; i++) begin : g_flag
      if (DLIR_IMPL_BITS[i]) begin : g_impl
        dlir_evt_latch u_latch (
          .ref_clk_i(ref_clk_i),
          .reset_i(reset_i),
          .ce_i(ce_i),
          .set_i(set_vec[i]),
          .clr_i(clr_vec[i]),
          .flag_o(status_q[i])
        );
      end else begin : g_resv
        assign status_q[i] = 1'b0; // R5
      end
    end
  endgenerate

  // an event only reaches the pin while both its enable and mask are set
  assign pending = status_q & enable_q & mask_q; // R1 R2 R3 R4
  // level output: stays high until software clears the flag behind it, or that flag's enable or mask bit
  assign irq_o = |pending;

  // zero wait states; stalls the bus while the clock enable is low
  assign hreadyout_o = ce_i;
  assign hresp_o = DLIR_HRESP_OKAY;
  assign hrdata_o = rdata_q;

  // the checks that expect the pin to rise skip cycles with a data-phase write, which may move enable or mask

  a_tx_begin_irq: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R1
    (ce_i && evt_i.tx_begin && enable_q[DLIR_BIT_TX_BEGIN] && mask_q[DLIR_BIT_TX_BEGIN] && !dp_q.write)
    |=> irq_o)
    else $error("tx start event with enable set gave no interrupt");

  a_tx_begin_off: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R1
    (!enable_q[DLIR_BIT_TX_BEGIN] && status_q[DLIR_BIT_TX_BEGIN] && !status_q[DLIR_BIT_RX_BEGIN]
     && !status_q[DLIR_BIT_TX_DONE] && !status_q[DLIR_BIT_RX_DONE]) |-> !irq_o)
    else $error("disabled tx start event raised the interrupt");

  a_rx_begin_irq: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R2
    (ce_i && evt_i.rx_begin && enable_q[DLIR_BIT_RX_BEGIN] && mask_q[DLIR_BIT_RX_BEGIN] && !dp_q.write)
    |-> ##1 irq_o)
    else $error("rx start event with enable set gave no interrupt");

  a_tx_done_gate: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R3
    (!enable_q[DLIR_BIT_TX_DONE] && status_q[DLIR_BIT_TX_DONE] && !status_q[DLIR_BIT_TX_BEGIN]
     && !status_q[DLIR_BIT_RX_BEGIN] && !status_q[DLIR_BIT_RX_DONE]) |-> !irq_o)
    else $error("disabled tx done event raised the interrupt");

  a_tx_done_flag: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R3
    (ce_i && evt_i.tx_done) |=> status_q[DLIR_BIT_TX_DONE])
    else $error("tx done event not recorded in status");

  a_rx_done_irq: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R4
    (ce_i && evt_i.rx_done && enable_q[DLIR_BIT_RX_DONE] && mask_q[DLIR_BIT_RX_DONE] && !dp_q.write)
    |=> irq_o ##0 status_q[DLIR_BIT_RX_DONE])
    else $error("rx done event with enable set gave no interrupt");

  a_resv_reads_zero: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R5
    (accept && !hwrite_i && ap_sel == DLIR_SEL_ENABLE) |=> !hrdata_o[DLIR_BIT_RESERVED])
    else $error("reserved enable bit read as one");

  a_enable_reset: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R5
    $fell(reset_i) |-> (enable_q == DLIR_ENABLE_RST && status_q == DLIR_STATUS_RST))
    else $error("enable or status not cleared by reset");

  a_status_rd_clr: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R6
    (rd_status && evt_i == '0) |=> (status_q == DLIR_STATUS_RST))
    else $error("status read did not clear the flags");

  a_set_wins: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R6
    (rd_status && evt_i.rx_begin) |=> status_q[DLIR_BIT_RX_BEGIN])
    else $error("event lost on clearing read");

  // gating for rx start and rx done, each with every other flag clear so the enable alone decides
  a_rx_begin_gate: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R2
    (!enable_q[DLIR_BIT_RX_BEGIN] && status_q[DLIR_BIT_RX_BEGIN] && !status_q[DLIR_BIT_TX_BEGIN]
     && !status_q[DLIR_BIT_TX_DONE] && !status_q[DLIR_BIT_RX_DONE]) |-> !irq_o)
    else $error("disabled rx start event raised the interrupt");

  a_rx_done_gate: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R4
    (!enable_q[DLIR_BIT_RX_DONE] && status_q[DLIR_BIT_RX_DONE] && !status_q[DLIR_BIT_TX_BEGIN]
     && !status_q[DLIR_BIT_RX_BEGIN] && !status_q[DLIR_BIT_TX_DONE]) |-> !irq_o)
    else $error("disabled rx done event raised the interrupt");

  a_tx_done_irq: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R3
    (ce_i && evt_i.tx_done && enable_q[DLIR_BIT_TX_DONE] && mask_q[DLIR_BIT_TX_DONE] && !dp_q.write)
    |=> irq_o)
    else $error("tx done event with enable set gave no interrupt");

  // flags record events whatever the enables say
  a_tx_begin_flag: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R1
    (ce_i && evt_i.tx_begin) |=> status_q[DLIR_BIT_TX_BEGIN])
    else $error("tx start event not recorded in status");

  a_rx_begin_flag: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R2
    (ce_i && evt_i.rx_begin) |=> status_q[DLIR_BIT_RX_BEGIN])
    else $error("rx start event not recorded in status");

  a_rx_done_flag: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R4
    (ce_i && evt_i.rx_done) |=> status_q[DLIR_BIT_RX_DONE])
    else $error("rx done event not recorded in status");

  // register side: what software writes and reads back, and the pin after a status read
  a_enable_resv: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R5
    (enable_q & ~DLIR_IMPL_BITS) == 8'h00)
    else $error("unimplemented enable bit holds a one");

  a_tx_done_reset: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R5
    $fell(reset_i) |-> !enable_q[DLIR_BIT_TX_DONE])
    else $error("tx done enable not cleared by reset");

  a_enable_write: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R1 R2 R3 R4
    (ce_i && wr_enable)
    |=> (enable_q[DLIR_BIT_TX_BEGIN:DLIR_BIT_RX_DONE] == $past(hwdata_i[DLIR_BIT_TX_BEGIN:DLIR_BIT_RX_DONE])))
    else $error("enable write did not land");

  a_irq_drops: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R6
    (rd_status && evt_i == '0) |=> !irq_o)
    else $error("interrupt stayed high after the status read");

  a_rdata_enable: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R1 R2 R3 R4
    (accept && !hwrite_i && ap_sel == DLIR_SEL_ENABLE && !wr_enable)
    |=> (hrdata_o[DLIR_REG_W-1:0] == $past(enable_q)))
    else $error("enable read back differs from the register");

  a_status_read: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R6
    (accept && !hwrite_i && ap_sel == DLIR_SEL_STATUS)
    |=> (hrdata_o[DLIR_REG_W-1:0] == $past(status_q)))
    else $error("status read did not return the flags seen before the read");

endmodule : dlir_top
`default_nettype wire
